// File: design/icf_bank.sv
// Configuration-variable bank: APB registers, paged function map, motor regulation settings
// Functional notes
// - Speed step one uses its own slow-step gain instead of the general gain.
// - Regulation frequency adapts unless bit 4 of regulation options is set.
// - Control influence of zero switches load compensation off completely.
// - Carrier runs at 40 kHz; clearing motor config bit 1 halves it.
// - Control influence scales the regulation strength from none to full.
// - Six physical outputs: head, rear and four spare outputs.
// - Variables 257 to 511 are paged by the two index variables.
// - Variables 1 to 256 do not depend on the index variables.
// - Keys mapped to one output are ORed together.
// - Each key has three control variables, forward and reverse sets.
// - One mapping entry may switch several outputs, one bit each.
// - Spare output four then stays on at standstill and running, both directions.
// - General gain sets how strongly regulation corrects speed errors.
//
// The implementer's own choice: the APB register port.
module icf_bank #(
  parameter int NUM_PAGES = 2,
  parameter int NUM_KEYS = NUM_PAGES * icf_pkg::KEYS_PER_PAGE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] speed_step,
  input wire logic drive_reverse,
  input wire logic [NUM_KEYS-3:0] fn_keys,
  output logic head_light,
  output logic rear_light,
  output logic spare_output_one,
  output logic spare_output_two,
  output logic spare_output_three,
  output logic spare_output_four,
  output logic regulation_enable,
  output logic adaptive_freq,
  output logic [7:0] effective_gain,
  output logic carrier_tick
);
  localparam int ENTRIES = NUM_KEYS * 2 * icf_pkg::CTL_PER_KEY;
  localparam int EW = $clog2(ENTRIES);

  logic [7:0] page_low_reg;
  logic [7:0] page_high_reg;
  logic [7:0] motor_cfg_reg;
  logic [7:0] slow_gain_reg;
  logic [7:0] gain_reg;
  logic [7:0] influence_reg;
  logic [7:0] reg_opts_reg;
  logic [7:0] ctl_mem [ENTRIES];
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Read by the status variable before the mapper and carrier logic below
  logic [5:0] fn_out;
  wire logic carrier_half;

  // Address decode
  wire logic [8:0] cv = paddr[icf_pkg::ADDR_MSB:icf_pkg::ADDR_LSB];
  wire logic addr_ok = (paddr[1:0] == 2'b00) && (paddr[11] == 1'b0) && (cv != 9'h000);
  wire logic in_paged = (cv >= icf_pkg::IDX_PAGED_FIRST);
  wire logic [8:0] map_off = cv - icf_pkg::IDX_MAP_BASE;
  wire logic [7:0] page_rel = page_high_reg - icf_pkg::MAP_PAGE_FIRST;
  wire logic page_hit = (page_low_reg == icf_pkg::MAP_PAGE_LOW) && (page_rel < 8'(NUM_PAGES));
  wire logic slot_hit = (cv >= icf_pkg::IDX_MAP_BASE) && (map_off[3:0] < 4'(icf_pkg::CTL_PER_KEY));
  wire logic map_hit = in_paged && page_hit && slot_hit;
  wire logic [7:0] key_no = 8'(page_rel * icf_pkg::KEYS_PER_PAGE) + {5'h00, map_off[7:5]};
  wire logic [EW-1:0] map_idx = EW'((key_no * 2 + {7'h00, map_off[4]}) * icf_pkg::CTL_PER_KEY + map_off[1:0]);

  // Read selection; the unpaged variables ignore the index variables
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (in_paged)
      rd_byte = map_hit ? ctl_mem[map_idx] : 8'h00;
    else if (cv == icf_pkg::IDX_PAGE_LOW)
      rd_byte = page_low_reg;
    else if (cv == icf_pkg::IDX_PAGE_HIGH)
      rd_byte = page_high_reg;
    else if (cv == icf_pkg::IDX_MOTOR_CFG)
      rd_byte = motor_cfg_reg;
    else if (cv == icf_pkg::IDX_SLOW_GAIN)
      rd_byte = slow_gain_reg;
    else if (cv == icf_pkg::IDX_GAIN)
      rd_byte = gain_reg;
    else if (cv == icf_pkg::IDX_INFLUENCE)
      rd_byte = influence_reg;
    else if (cv == icf_pkg::IDX_REG_OPTS)
      rd_byte = reg_opts_reg;
    else if (cv == icf_pkg::IDX_STATUS)
      rd_byte = {1'b0, carrier_half, regulation_enable, adaptive_freq, 4'h0} | {2'b00, fn_out};
  end

  // APB handshake: one wait cycle, write commits with pready high
  wire logic access = psel && penable;
  wire logic commit = access && pready_reg;
  wire logic do_write = commit && pwrite && addr_ok && pstrb[0];
  wire logic wr_cfg = do_write && !in_paged;
  wire logic wr_map = do_write && map_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !addr_ok;
      if (access && !pready_reg)
        prdata_reg <= (!pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // Write strobes of the unpaged variables
  wire logic wr_page_low = wr_cfg && (cv == icf_pkg::IDX_PAGE_LOW);
  wire logic wr_page_high = wr_cfg && (cv == icf_pkg::IDX_PAGE_HIGH);
  wire logic wr_motor_cfg = wr_cfg && (cv == icf_pkg::IDX_MOTOR_CFG);
  wire logic wr_slow_gain = wr_cfg && (cv == icf_pkg::IDX_SLOW_GAIN);
  wire logic wr_gain = wr_cfg && (cv == icf_pkg::IDX_GAIN);
  wire logic wr_influence = wr_cfg && (cv == icf_pkg::IDX_INFLUENCE);
  wire logic wr_reg_opts = wr_cfg && (cv == icf_pkg::IDX_REG_OPTS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_low_reg <= icf_pkg::RST_PAGE_LOW;
    else if (wr_page_low)
      page_low_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_high_reg <= icf_pkg::RST_PAGE_HIGH;
    else if (wr_page_high)
      page_high_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      motor_cfg_reg <= icf_pkg::RST_MOTOR_CFG;
    else if (wr_motor_cfg)
      motor_cfg_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slow_gain_reg <= icf_pkg::RST_SLOW_GAIN;
    else if (wr_slow_gain)
      slow_gain_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_reg <= icf_pkg::RST_GAIN;
    else if (wr_gain)
      gain_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      influence_reg <= icf_pkg::RST_INFLUENCE;
    else if (wr_influence)
      influence_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reg_opts_reg <= icf_pkg::RST_REG_OPTS;
    else if (wr_reg_opts)
      reg_opts_reg <= pwdata[7:0];
  end

  // Control storage of the mapping bank, cleared at reset
  genvar e;
  generate
    for (e = 0; e < ENTRIES; e++)
    begin : g_ctl
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctl_mem[e] <= 8'h00;
        else if (wr_map && (map_idx == EW'(e)))
          ctl_mem[e] <= pwdata[7:0];
      end
    end
  endgenerate

  // Function mapping: key 0 standstill, key 1 running, then F0 upward
  icf_map_if #(.NUM_KEYS(NUM_KEYS)) mif ();
  genvar m;
  generate
    for (m = 0; m < NUM_KEYS; m++)
    begin : g_map
      assign mif.map_fwd[m*8 +: 8] = ctl_mem[(m*2) * icf_pkg::CTL_PER_KEY];
      assign mif.map_rev[m*8 +: 8] = ctl_mem[(m*2 + 1) * icf_pkg::CTL_PER_KEY];
    end
  endgenerate
  // Standstill and running keys keep e.g. a driver supply alive in every state
  wire logic moving = (speed_step != 8'h00);
  assign mif.keys = {fn_keys, moving, !moving};
  assign mif.reverse = drive_reverse;
  assign fn_out = mif.outs;

  icf_out_mapper #(.NUM_KEYS(NUM_KEYS)) u_mapper (
    .pclk(pclk),
    .presetn(presetn),
    .mif(mif)
  );

  // Regulation settings
  assign carrier_half = !motor_cfg_reg[icf_pkg::MOTOR_CFG_FULL_PWM_BIT];
  wire logic slow_step = (speed_step == 8'(icf_pkg::SLOW_SPEED_STEP));
  wire logic [7:0] active_gain = slow_step ? slow_gain_reg : gain_reg;
  wire logic [15:0] scaled = active_gain * influence_reg;
  wire logic full_inf = (influence_reg == 8'hFF);
  wire logic [7:0] gain_next = full_inf ? active_gain : scaled[15:8];
  logic regulation_enable_reg;
  logic adaptive_freq_reg;
  logic [7:0] effective_gain_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regulation_enable_reg <= 1'b0;
      adaptive_freq_reg <= 1'b0;
      effective_gain_reg <= 8'h00;
    end
    else
    begin
      regulation_enable_reg <= (influence_reg != 8'h00);
      adaptive_freq_reg <= !reg_opts_reg[icf_pkg::REG_OPTS_FIXED_FREQ_BIT];
      effective_gain_reg <= (influence_reg == 8'h00) ? 8'h00 : gain_next;
    end
  end

  // Regulation carrier: 625 cycles at full rate, 1250 at half rate
  localparam int CW = $clog2(icf_pkg::PWM_HALF_CYCLES);
  logic [CW-1:0] carrier_cnt_reg;
  logic carrier_tick_reg;
  wire logic [CW-1:0] carrier_last = carrier_half ? CW'(icf_pkg::PWM_HALF_CYCLES - 1) :
                                     CW'(icf_pkg::PWM_FULL_CYCLES - 1);
  wire logic carrier_wrap = (carrier_cnt_reg >= carrier_last);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carrier_cnt_reg <= '0;
      carrier_tick_reg <= 1'b0;
    end
    else
    begin
      carrier_cnt_reg <= carrier_wrap ? '0 : carrier_cnt_reg + 1'b1;
      carrier_tick_reg <= carrier_wrap;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign head_light = fn_out[0];
  assign rear_light = fn_out[1];
  assign spare_output_one = fn_out[2];
  assign spare_output_two = fn_out[3];
  assign spare_output_three = fn_out[4];
  assign spare_output_four = fn_out[5];
  assign regulation_enable = regulation_enable_reg;
  assign adaptive_freq = adaptive_freq_reg;
  assign effective_gain = effective_gain_reg;
  assign carrier_tick = carrier_tick_reg;
endmodule : icf_bank

// File: design/icf_pkg.sv
// Constants, register indices and field layout of the configuration-variable bank
package icf_pkg;
  // Variable numbers; the bus byte address is four times the number
  localparam logic [8:0] IDX_PAGE_LOW = 9'h01F;
  localparam logic [8:0] IDX_PAGE_HIGH = 9'h020;
  localparam logic [8:0] IDX_MOTOR_CFG = 9'h031;
  localparam logic [8:0] IDX_SLOW_GAIN = 9'h034;
  localparam logic [8:0] IDX_GAIN = 9'h036;
  localparam logic [8:0] IDX_INFLUENCE = 9'h038;
  localparam logic [8:0] IDX_REG_OPTS = 9'h07C;
  localparam logic [8:0] IDX_STATUS = 9'h0FF;
  localparam logic [8:0] IDX_PAGED_FIRST = 9'h101;
  localparam logic [8:0] IDX_MAP_BASE = 9'h10A;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 10;
  // Paged mapping area: index low selects the mapping bank, index high the page
  localparam logic [7:0] MAP_PAGE_LOW = 8'h10;
  localparam logic [7:0] MAP_PAGE_FIRST = 8'h02;
  localparam int KEYS_PER_PAGE = 8;
  localparam int CTL_PER_KEY = 3;
  // Field positions
  localparam int MOTOR_CFG_FULL_PWM_BIT = 1;
  localparam int REG_OPTS_FIXED_FREQ_BIT = 4;
  localparam int NUM_OUTPUTS = 6;
  localparam int SLOW_SPEED_STEP = 1;
  // Reset values
  localparam logic [7:0] RST_PAGE_LOW = 8'h10;
  localparam logic [7:0] RST_PAGE_HIGH = 8'h02;
  localparam logic [7:0] RST_MOTOR_CFG = 8'h02;
  localparam logic [7:0] RST_SLOW_GAIN = 8'h20;
  localparam logic [7:0] RST_GAIN = 8'h30;
  localparam logic [7:0] RST_INFLUENCE = 8'hFF;
  localparam logic [7:0] RST_REG_OPTS = 8'h00;
  // Timing: regulation carrier
  localparam int CLK_HZ = 25_000_000;
  localparam int PWM_FULL_HZ = 40_000;
  localparam int PWM_FULL_CYCLES = CLK_HZ / PWM_FULL_HZ;
  localparam int PWM_HALF_CYCLES = 2 * PWM_FULL_CYCLES;
endpackage : icf_pkg

// File: design/icf_map_if.sv
// Signals between the register bank and the function output mapper
interface icf_map_if #(parameter int NUM_KEYS = 16);
  logic [NUM_KEYS*8-1:0] map_fwd;
  logic [NUM_KEYS*8-1:0] map_rev;
  logic [NUM_KEYS-1:0] keys;
  logic reverse;
  logic [5:0] outs;
  modport bank (output map_fwd, output map_rev, output keys, output reverse, input outs);
  modport mapper (input map_fwd, input map_rev, input keys, input reverse, output outs);
endinterface : icf_map_if

// File: design/icf_out_mapper.sv
// Combines active keys through their mapping bytes into the physical outputs
module icf_out_mapper #(
  parameter int NUM_KEYS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  icf_map_if.mapper mif
);
  logic [NUM_KEYS*8-1:0] sel_map;
  logic [5:0] outs_next;
  logic [5:0] outs_reg;

  genvar k;
  genvar b;
  generate
    for (k = 0; k < NUM_KEYS; k++)
    begin : g_key
      // Direction picks the forward or reverse entry of each key
      assign sel_map[k*8 +: 8] = mif.keys[k] ? (mif.reverse ? mif.map_rev[k*8 +: 8] : mif.map_fwd[k*8 +: 8]) : 8'h00;
    end
    for (b = 0; b < 6; b++)
    begin : g_bit
      logic [NUM_KEYS-1:0] col;
      for (k = 0; k < NUM_KEYS; k++)
      begin : g_col
        assign col[k] = sel_map[k*8 + b];
      end
      assign outs_next[b] = |col;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      outs_reg <= 6'h00;
    else
      outs_reg <= outs_next;
  end

  assign mif.outs = outs_reg;
endmodule : icf_out_mapper

// File: tb/icf_bank_chk.sv
// Checker of bus timing and regulation outputs of the variable bank
module icf_bank_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic regulation_enable,
  input wire logic adaptive_freq,
  input wire logic [7:0] effective_gain,
  input wire logic carrier_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_reg;
  logic [10:0] gap_reg;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Outputs settle one edge after reset, so change checks wait two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_reg <= 2'h0;
      gap_reg <= 11'h000;
    end
    else
    begin
      up_reg <= {up_reg[0], 1'b1};
      gap_reg <= carrier_tick ? 11'h000 : gap_reg + 11'h001;
    end
  end
  sequence acc_s;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  sequence wr_done_s;
    $past(pready && pwrite, 2) || $past(pready && pwrite);
  endsequence
  apb_wait_a: assert property ($rose(penable) && psel |-> acc_s) else $error("access phase not one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_top_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000) else $error("read data upper bits set");
  bad_index_a: assert property (psel && !penable && paddr[10:2] == 9'h000 |-> ##2 pslverr)
    else $error("variable zero not refused");
  no_feedback_a: assert property (!regulation_enable |-> effective_gain == 8'h00) else $error("gain while off");
  freq_cause_a: assert property (up_reg[1] && $changed(adaptive_freq) |-> wr_done_s) else $error("freq mode moved");
  regen_cause_a: assert property (up_reg[1] && $changed(regulation_enable) |-> wr_done_s) else $error("enable moved");
  carrier_gap_a: assert property (gap_reg <= 11'h4E1) else $error("carrier period too long");
endmodule : icf_bank_chk

bind icf_bank icf_bank_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .regulation_enable(regulation_enable),
  .adaptive_freq(adaptive_freq), .effective_gain(effective_gain), .carrier_tick(carrier_tick));

// File: tb/icf_throttle.sv
// Throttle side of the command station: speed, direction and function keys
module icf_throttle #(
  parameter int NK = 14
) (
  input wire logic pclk,
  output logic [7:0] speed_step,
  output logic drive_reverse,
  output logic [NK-1:0] fn_keys
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    speed_step = 8'h00;
    drive_reverse = 1'b0;
    fn_keys = '0;
  end
  task automatic drive(input logic [7:0] s, input logic r, input logic [NK-1:0] k);
    @(posedge pclk);
    speed_step <= s;
    drive_reverse <= r;
    fn_keys <= k;
  endtask : drive
endmodule : icf_throttle

// File: tb/icf_bank_bench.sv
// Self-checking bench of the variable bank over its register bus
module icf_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] speed_step;
  logic drive_reverse;
  logic [13:0] fn_keys;
  wire logic [5:0] outs;
  logic regulation_enable;
  logic adaptive_freq;
  logic [7:0] effective_gain;
  logic carrier_tick;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_compared = 0;
  logic [8:0] ri [6] = '{9'h01F, 9'h020, 9'h031, 9'h034, 9'h038, 9'h07C};
  logic [7:0] rv [6] = '{8'h10, 8'h02, 8'h02, 8'h20, 8'hFF, 8'h00};
  always #20 pclk = ~pclk;
  icf_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_step(speed_step),
    .drive_reverse(drive_reverse), .fn_keys(fn_keys), .head_light(outs[0]), .rear_light(outs[1]),
    .spare_output_one(outs[2]), .spare_output_two(outs[3]), .spare_output_three(outs[4]),
    .spare_output_four(outs[5]), .regulation_enable(regulation_enable), .adaptive_freq(adaptive_freq),
    .effective_gain(effective_gain), .carrier_tick(carrier_tick));
  icf_throttle #(.NK(14)) thr (.pclk(pclk), .speed_step(speed_step), .drive_reverse(drive_reverse), .fn_keys(fn_keys));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [8:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task automatic rdck(input logic [8:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask : rdck
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask : settle
  // Counts the cycles of one whole carrier period
  task automatic gap(input int exp);
    int n;
    n = 0;
    do @(posedge pclk); while (carrier_tick !== 1'b1);
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (carrier_tick !== 1'b1);
    check(n, exp);
  endtask : gap
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial
  begin
    #400_000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdck(ri[i], rv[i]);
    rdck(9'h000, 8'h00);
    check(er, 1'b1);
    $display("Test reset and refusal done");
    wr(9'h01F, 8'h10);
    wr(9'h020, 8'h02);
    wr(9'h10A, 8'h11);
    wr(9'h020, 8'h03);
    rdck(9'h10A, 8'h00);
    wr(9'h10A, 8'h22);
    rdck(9'h031, 8'h02);
    wr(9'h020, 8'h02);
    rdck(9'h10A, 8'h11);
    $display("Test paged access done");
    wr(9'h10A, 8'h00);
    wr(9'h14A, 8'h05);
    wr(9'h16A, 8'h04);
    wr(9'h15A, 8'h02);
    thr.drive(8'h00, 1'b0, 14'h0003);
    settle();
    check(outs, 6'h05);
    thr.drive(8'h00, 1'b0, 14'h0002);
    settle();
    check(outs, 6'h04);
    thr.drive(8'h00, 1'b1, 14'h0001);
    settle();
    check(outs, 6'h02);
    wr(9'h14A, 8'h00);
    wr(9'h15A, 8'h00);
    wr(9'h16A, 8'h00);
    $display("Test key mapping done");
    wr(9'h038, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(9'h10A + 9'h010 * i[8:0], 8'h20);
    for (int i = 0; i < 4; i++)
    begin
      thr.drive(i[1] ? 8'h05 : 8'h00, i[0], 14'h0000);
      settle();
      check(outs, 6'h20);
    end
    check(regulation_enable, 1'b0);
    check(effective_gain, 8'h00);
    $display("Test sine driver setup done");
    wr(9'h038, 8'hFF);
    thr.drive(8'h01, 1'b0, 14'h0000);
    settle();
    check(effective_gain, 8'h20);
    thr.drive(8'h05, 1'b0, 14'h0000);
    wr(9'h038, 8'h80);
    settle();
    check(effective_gain, 8'h18);
    wr(9'h036, 8'h40);
    wr(9'h038, 8'hFF);
    settle();
    check(effective_gain, 8'h40);
    $display("Test gain done");
    check(adaptive_freq, 1'b1);
    wr(9'h07C, 8'h10);
    settle();
    check(adaptive_freq, 1'b0);
    gap(625);
    wr(9'h031, 8'h00);
    gap(1250);
    $display("Test carrier done");
    wrap_up();
  end
endmodule : icf_bank_bench
